/* inc/pic_pkg.sv */
// constants and register map for the prioritized interrupt controller
package pic_pkg;
    localparam int NCH = 15;
    localparam logic [7:0] OFF_TRIG_HI = 8'h00;
    localparam logic [7:0] OFF_TRIG_LO = 8'h04;
    localparam logic [7:0] OFF_SENSE = 8'h08;
    localparam logic [7:0] OFF_CLEAR = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_LEVEL = 8'h14;
    localparam logic [7:0] OFF_MODE = 8'h18;
    localparam logic [15:0] MASK_RESET = 16'hFFFF;
    localparam int LEVEL_CLEAR_BIT = 4;
    localparam int LEVEL_MASK_BIT = 0;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {
        TRIG_HIGH = 2'b00,
        TRIG_LOW = 2'b01,
        TRIG_RISE = 2'b10,
        TRIG_FALL = 2'b11
    } pic_trig_type;
    typedef enum logic [1:0] {
        MODE_PASS = 2'b00,
        MODE_ENABLED = 2'b01
    } pic_mode_type;
endpackage : pic_pkg

/* verilog/pic_top.sv */
// prioritized interrupt controller with apb register slave
// How it works
// (RULE_01) two-bit trigger per channel: high, low, rise, fall; reset high
// (RULE_02) trigger register hi holds channels 8-15, register lo channels 1-7
// (RULE_03) channels without pins read low internally
// (RULE_04) detected trigger sets read-only sense bit; reset clears sense
// (RULE_05) software programs triggers and clears pending before enabling
// (RULE_06) mode 00: level pins pass straight to the core
// (RULE_07) mode 01: level pins become requests 15..12, requests 11..8 usable
// (RULE_08) software never writes mode values 10 or 11
// (RULE_09) when enabled, requests 15..1 recorded in sense on trigger
// (RULE_10) highest unmasked sensed request is encoded into level latch
// (RULE_11) latched level reaches core only while level mask bit clear
// (RULE_12) writing one to level clear bit empties the level latch
// (RULE_13) pending unmasked requests load into latch one after another
// (RULE_14) reset sets every mask bit
// (RULE_15) writing one to clear bit n clears sense bit n
// (RULE_16) software clears sense bit first, then writes level clear
// (RULE_17) level mask set: still latch, no trap; nonzero latch means pending
// (RULE_18) sense bits readable for masked channels
// (RULE_19) fifteen levels, level 15 non-maskable by core
// (RULE_20) higher channel number wins; level equals channel number
// (RULE_21) inputs synchronised, edges from current versus previous sample
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pic_top
    import pic_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [11:8] irq_pin_in,
    input wire logic [3:0] level_pin_in,
    output logic [3:0] core_level_out
);
    logic [11:8] irq_s1_r;
    logic [11:8] irq_s2_r;
    logic [3:0] lvl_s1_r;
    logic [3:0] lvl_s2_r;
    logic [15:1] prev_r;
    logic [15:0] trig_hi_r;
    logic [13:0] trig_lo_r;
    logic [15:1] sense_r;
    logic [15:0] mask_r;
    logic [3:0] latch_r;
    logic [1:0] mode_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [3:0] core_level_r;

    // two-flop synchronisers on all irq and level pins
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            irq_s1_r <= 4'h0;
            irq_s2_r <= 4'h0;
            lvl_s1_r <= 4'h0;
            lvl_s2_r <= 4'h0;
        end
        else
        begin
            irq_s1_r <= irq_pin_in; // RULE_21
            irq_s2_r <= irq_s1_r;
            lvl_s1_r <= level_pin_in;
            lvl_s2_r <= lvl_s1_r;
        end
    end

    wire enabled = (mode_r == MODE_ENABLED);
    wire [15:1] req_now;
    // pinless channels held low; 11..8 and 15..12 only when enabled
    assign req_now = enabled ? {lvl_s2_r, irq_s2_r, 7'h00}
                             : 15'h0000; // RULE_03 RULE_07
    wire [29:0] trig_all = {trig_hi_r, trig_lo_r}; // RULE_02

    // per-channel trigger detection
    logic [15:1] hit;
    always_comb
    begin
        for (int n = 1; n <= NCH; n++)
        begin
            unique case (pic_trig_type'(trig_all[2*n-2 +: 2])) // RULE_01
                TRIG_HIGH: hit[n] = req_now[n];
                TRIG_LOW: hit[n] = !req_now[n];
                TRIG_RISE: hit[n] = req_now[n] && !prev_r[n]; // RULE_21
                TRIG_FALL: hit[n] = !req_now[n] && prev_r[n];
            endcase
        end
    end

    // apb decode
    wire access = psel_in && penable_in;
    wire wr = access && pwrite_in;
    wire known = (paddr_in == OFF_TRIG_HI) || (paddr_in == OFF_TRIG_LO) ||
        (paddr_in == OFF_SENSE) || (paddr_in == OFF_CLEAR) ||
        (paddr_in == OFF_MASK) || (paddr_in == OFF_LEVEL) ||
        (paddr_in == OFF_MODE);
    wire wr_clear = wr && (paddr_in == OFF_CLEAR);
    wire wr_level_clr = wr && (paddr_in == OFF_LEVEL) &&
        pwdata_in[LEVEL_CLEAR_BIT];
    wire [15:1] clr_bits = wr_clear ? pwdata_in[15:1] : 15'h0000;
    // clear bits not re-set by a same-cycle hit
    wire [15:1] clr_only = clr_bits & ~hit;

    // priority encode: highest channel number wins
    wire [15:1] pending = sense_r & ~mask_r[15:1]; // RULE_10
    logic [3:0] winner;
    always_comb
    begin
        winner = 4'h0;
        for (int n = 1; n <= NCH; n++)
        begin
            if (pending[n])
                winner = 4'(n); // RULE_20
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            prev_r <= 15'h0000;
            sense_r <= 15'h0000; // RULE_04
        end
        else
        begin
            prev_r <= req_now;
            // set wins over clear
            sense_r <= (sense_r & ~clr_bits) |
                (enabled ? hit : 15'h0000); // RULE_04 RULE_09 RULE_15
        end
    end

    // level latch: loads when empty, emptied by clear bit
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            latch_r <= 4'h0;
        else if (wr_level_clr)
            latch_r <= 4'h0; // RULE_12
        else if (latch_r == 4'h0)
            latch_r <= winner; // RULE_10 RULE_13 RULE_17
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            trig_hi_r <= 16'h0000; // RULE_01
            trig_lo_r <= 14'h0000;
            mask_r <= MASK_RESET; // RULE_14
            mode_r <= MODE_PASS;
        end
        else if (wr)
        begin
            if (paddr_in == OFF_TRIG_HI)
                trig_hi_r <= pwdata_in[15:0];
            if (paddr_in == OFF_TRIG_LO)
                trig_lo_r <= pwdata_in[13:0];
            if (paddr_in == OFF_MASK)
                mask_r <= pwdata_in[15:0];
            if (paddr_in == OFF_MODE)
                mode_r <= pwdata_in[1:0];
        end
    end

    // read mux; clear register reads zero
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = UNMAPPED_DATA;
        unique case (paddr_in)
            OFF_TRIG_HI: rd_mux = {16'h0000, trig_hi_r};
            OFF_TRIG_LO: rd_mux = {18'h0_0000, trig_lo_r};
            OFF_SENSE: rd_mux = {16'h0000, sense_r, 1'b0}; // RULE_18
            OFF_MASK: rd_mux = {16'h0000, mask_r};
            OFF_LEVEL: rd_mux = {28'h000_0000, latch_r}; // RULE_17
            OFF_MODE: rd_mux = {30'h0000_0000, mode_r};
            default: rd_mux = UNMAPPED_DATA;
        endcase
    end

    // no wait state: setup, access(ready)
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= psel_in && !penable_in;
            pslverr_r <= psel_in && !penable_in && !known;
            prdata_r <= rd_mux;
        end
    end
    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;

    // core level: bypass, or latch gated by level mask bit
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            core_level_r <= 4'h0;
        else if (!enabled)
            core_level_r <= lvl_s2_r; // RULE_06
        else if (!mask_r[LEVEL_MASK_BIT])
            core_level_r <= latch_r; // RULE_11 RULE_19
        else
            core_level_r <= 4'h0; // RULE_17
    end
    assign core_level_out = core_level_r;


    // reset values
    AST_SENSE_RESET: assert property ( // RULE_04
        @(posedge clock_in)
        $rose(rstn_in) |-> sense_r == 15'h0000)
        else $error("sense not clear after reset");
    AST_MASK_RESET: assert property ( // RULE_14
        @(posedge clock_in)
        $rose(rstn_in) |-> mask_r == MASK_RESET)
        else $error("mask not set after reset");
    AST_TRIG_RESET: assert property ( // RULE_01
        @(posedge clock_in)
        $rose(rstn_in) |-> trig_hi_r == 16'h0000 && trig_lo_r == 14'h0000)
        else $error("trigger modes not high level after reset");
    AST_MODE_RESET: assert property ( // RULE_06
        @(posedge clock_in)
        $rose(rstn_in) |-> mode_r == MODE_PASS)
        else $error("controller not bypassed after reset");

    // level latch and core level
    AST_LEVEL_CLEAR: assert property ( // RULE_12
        @(posedge clock_in) disable iff (!rstn_in)
        wr_level_clr |=> latch_r == 4'h0)
        else $error("level latch not cleared");
    AST_LOAD_WINNER: assert property ( // RULE_13
        @(posedge clock_in) disable iff (!rstn_in)
        (latch_r == 4'h0 && !wr_level_clr) |=> latch_r == $past(winner))
        else $error("latch did not load winner");
    AST_LATCH_HOLD: assert property ( // RULE_13
        @(posedge clock_in) disable iff (!rstn_in)
        (latch_r != 4'h0 && !wr_level_clr) |=> $stable(latch_r))
        else $error("latch changed while occupied");
    AST_BYPASS: assert property ( // RULE_06
        @(posedge clock_in) disable iff (!rstn_in)
        (!enabled) |=> core_level_out == $past(lvl_s2_r))
        else $error("bypass level wrong");
    AST_GATED: assert property ( // RULE_11
        @(posedge clock_in) disable iff (!rstn_in)
        (enabled && mask_r[0]) |=> core_level_out == 4'h0)
        else $error("trap raised while level mask set");
    AST_CORE_LEVEL: assert property ( // RULE_11
        @(posedge clock_in) disable iff (!rstn_in)
        (enabled && !mask_r[0]) |=> core_level_out == $past(latch_r))
        else $error("latched level not presented to core");
    AST_HIGHEST: assert property ( // RULE_20
        @(posedge clock_in) disable iff (!rstn_in)
        pending[15] |-> winner == 4'hF)
        else $error("channel 15 not highest");

    // request sense
    AST_SENSE_CLEAR: assert property ( // RULE_15
        @(posedge clock_in) disable iff (!rstn_in)
        wr_clear |=> (sense_r & $past(clr_only)) == 15'h0000)
        else $error("sense bit not cleared");
    AST_RECORD: assert property ( // RULE_09
        @(posedge clock_in) disable iff (!rstn_in)
        (enabled && hit[15]) |=> sense_r[15])
        else $error("request not recorded");
    AST_SENSE_IDLE: assert property ( // RULE_09
        @(posedge clock_in) disable iff (!rstn_in)
        (!enabled) |=> (sense_r & ~$past(sense_r)) == 15'h0000)
        else $error("request recorded while bypassed");
    AST_PINLESS_LOW: assert property ( // RULE_03
        @(posedge clock_in) disable iff (!rstn_in)
        (enabled && trig_all[1:0] == TRIG_LOW) |=> sense_r[1])
        else $error("pinless low-level channel not pending");
    AST_POLL_SENSE: assert property ( // RULE_18
        @(posedge clock_in) disable iff (!rstn_in)
        (psel_in && !penable_in && paddr_in == OFF_SENSE) |=>
            prdata_out == {16'h0000, $past(sense_r), 1'b0})
        else $error("sense read data wrong");

    // bus answer
    AST_READY_PULSE: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        (psel_in && !penable_in) |=> pready_out)
        else $error("no ready after setup cycle");
    AST_SLVERR: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        pslverr_out |-> pready_out)
        else $error("error response without ready");

    CVR_TRAP: cover property (@(posedge clock_in)
        core_level_out != 4'h0 && enabled);
    CVR_ACK: cover property (@(posedge clock_in)
        wr_level_clr && latch_r != 4'h0);
    CVR_POLL: cover property (@(posedge clock_in)
        mask_r[0] && latch_r != 4'h0);
    CVR_BYPASS: cover property (@(posedge clock_in)
        !enabled && core_level_out != 4'h0);
    CVR_EDGE: cover property (@(posedge clock_in)
        enabled && hit[8]);
endmodule : pic_top
`default_nettype wire

/* dv/pic_src.sv */
// model of external request sources and core level observer
`timescale 1ns/100ps
`default_nettype none
module pic_src (
    input wire logic clock_in,
    input wire logic [7:0] drive_in,
    input wire logic [3:0] core_level_in,
    output logic [3:0] irq_out,
    output logic [3:0] level_out,
    output logic trap_out
);
    initial
    begin
        irq_out = 4'h0;
        level_out = 4'h0;
    end
    always @(posedge clock_in)
    begin
        irq_out <= drive_in[3:0];
        level_out <= drive_in[7:4];
    end
    assign trap_out = core_level_in != 4'h0;
endmodule : pic_src
`default_nettype wire

/* dv/prioritized_interrupt_controller_test.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module prioritized_interrupt_controller_test;
    import pic_pkg::*;
    logic clock_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0;
    logic pwrite_in = 0, pready_out, pslverr_out, err, trap;
    logic [7:0] paddr_in = 8'h00, drive = 8'h0A;
    logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
    logic [3:0] irq, lvl, core_level_out;
    int num_errors = 0, tests_run = 0, cyc = 0, sense_m, w, r;
    pic_top u_dut (.clock_in(clock_in), .rstn_in(rstn_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .irq_pin_in(irq), .level_pin_in(lvl), .core_level_out(core_level_out));
    pic_src u_src (.clock_in(clock_in), .drive_in(drive),
        .core_level_in(core_level_out), .irq_out(irq), .level_out(lvl),
        .trap_out(trap));
    always #50 clock_in = ~clock_in;
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            num_errors++;
            final_report();
        end
    end
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do
            @(posedge clock_in);
        while (pready_out !== 1'b1 && ++n < 20);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    function automatic int top(input int v);
        top = 0;
        for (int i = 1; i < 16; i++)
            if (v[i])
                top = i;
    endfunction : top
    task final_report;
        $display("tests %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    initial
    begin
        r = $urandom(34);
        repeat (10) @(posedge clock_in);
        rstn_in <= 1'b1;
        r = $urandom % 16;
        drive <= {r[3:0], 4'hA};
        repeat (5) @(posedge clock_in);
        chk("bypass", 32'(core_level_out), r);
        apb(1'b0, OFF_MASK, 32'h0000_0000);
        chk("mask", rd, {16'h0000, MASK_RESET});
        apb(1'b0, OFF_SENSE, 32'h0000_0000);
        chk("sense0", rd, 32'h0000_0000);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
        $display("test reset and bypass done");
        drive <= 8'h0A;
        apb(1'b1, OFF_TRIG_HI, 32'h0000_004E);
        apb(1'b1, OFF_TRIG_LO, 32'h0000_0001);
        apb(1'b1, OFF_CLEAR, 32'h0000_FFFE);
        apb(1'b1, OFF_MODE, 32'h0000_0001);
        drive <= 8'h95;
        repeat (6) @(posedge clock_in);
        drive <= 8'h0A;
        sense_m = 32'h0000_9F02;
        apb(1'b0, OFF_SENSE, 32'h0000_0000);
        chk("sense", rd, sense_m);
        chk("masked", 32'(core_level_out), 0);
        apb(1'b1, OFF_MASK, 32'h0000_0801);
        repeat (4) @(posedge clock_in);
        apb(1'b0, OFF_LEVEL, 32'h0000_0000);
        chk("latch", rd, 32'h0000_000F);
        chk("notrap", 32'(core_level_out), 0);
        chk("notrap_core", 32'(trap), 0);
        apb(1'b1, OFF_MASK, 32'h0000_0800);
        for (int i = 0; i < 6; i++)
        begin
            w = top(sense_m & ~32'h0000_0800);
            repeat (4) @(posedge clock_in);
            chk("core", 32'(core_level_out), w);
            chk("trap", 32'(trap), 1);
            apb(1'b1, OFF_CLEAR, 32'(1 << w));
            apb(1'b1, OFF_LEVEL, 32'h0000_0010);
            if (w != 1)
                sense_m &= ~(1 << w);
        end
        apb(1'b0, OFF_SENSE, 32'h0000_0000);
        chk("poll", rd, sense_m);
        $display("test priority service done");
        final_report();
    end
endmodule : prioritized_interrupt_controller_test
`default_nettype wire
